// >>> hdl/mpm_pkg.sv
// Constants, offsets and mode encodings for the modem page register bank.
// Assumes word-aligned AXI4-Lite access, byte address = 4 * register index.
package mpm_pkg;

	// Register index width and byte address offset
	localparam int IDX_W = 7;
	localparam int IDX_LSB = 2;

	// Register indices
	localparam logic [6:0] IDX_FIFO = 7'h00;
	localparam logic [6:0] IDX_OPMODE = 7'h01;
	localparam logic [6:0] IDX_RSVD_A = 7'h02;
	localparam logic [6:0] IDX_RSVD_B = 7'h03;
	localparam logic [6:0] IDX_RSVD_C = 7'h04;
	localparam logic [6:0] IDX_RSVD_D = 7'h05;
	localparam logic [6:0] IDX_FRF_HIGH = 7'h06;
	localparam logic [6:0] IDX_FRF_MID = 7'h07;
	localparam logic [6:0] IDX_FRF_LOW = 7'h08;
	localparam logic [6:0] IDX_SHARED_LO = 7'h0D;
	localparam logic [6:0] IDX_SHARED_HI = 7'h3F;
	localparam logic [6:0] IDX_BAND_LO = 7'h61;
	localparam logic [6:0] IDX_BAND_HI = 7'h73;
	localparam int BAND_DEPTH = 19;

	// Mode control field positions
	localparam int OPM_FAMILY_BIT = 7;
	localparam int OPM_SHARED_BIT = 6;
	localparam int OPM_LOWBAND_BIT = 3;
	localparam int OPM_MODE_MSB = 2;

	// Values after reset
	localparam logic [7:0] FIFO_RST = 8'h00;
	localparam logic FAMILY_RST = 1'h0;
	localparam logic SHARED_RST = 1'h0;
	localparam logic LOWBAND_RST = 1'h1;
	localparam logic [7:0] FRF_HIGH_RST = 8'h6C;
	localparam logic [7:0] FRF_MID_RST = 8'h80;
	localparam logic [7:0] FRF_LOW_RST = 8'h00;
	localparam logic [7:0] BAND_RST = 8'h00;

	// Synthesizer scaling: f = reference_osc_freq * word / 2^FRF_FRAC_BITS
	localparam int REF_OSC_FREQ_MHZ = 32;
	localparam int FRF_FRAC_BITS = 19;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		MPM_SLEEP = 3'b000,
		MPM_STANDBY_STATE = 3'b001,
		MPM_TRANSMIT_SYNTH_MODE = 3'b010,
		MPM_TRANSMIT = 3'b011,
		MPM_RECEIVE_SYNTH_MODE = 3'b100,
		MPM_RECEIVE_STREAM_MODE = 3'b101,
		MPM_RECEIVE_ONCE_MODE = 3'b110,
		MPM_CHANNEL_ACTIVITY_CHECK = 3'b111
	} mpm_mode_t;

endpackage

// >>> hdl/mpm_band_store.sv
// Two retained banks of band-specific registers, one per frequency band.
// Assumes the parent presents one write strobe at a time on its own clock.
`timescale 1ns/1ns
module mpm_band_store
#(
	parameter int DEPTH = mpm_pkg::BAND_DEPTH
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic low_band_i,
	input wire logic wr_i,
	input wire logic [4:0] idx_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o
);
	import mpm_pkg::*;

	logic [DEPTH*8-1:0] lf_flat;
	logic [DEPTH*8-1:0] hf_flat;

	// One register pair per entry
	for (genvar g = 0; g < DEPTH; g++)
	begin : g_entry
		logic [7:0] lf_q;
		logic [7:0] hf_q;
		always_ff @(posedge clk_i)
		begin
			if (rst_i)
			begin
				lf_q <= BAND_RST;
				hf_q <= BAND_RST;
			end
			else if (wr_i && idx_i == 5'(g))
			begin
				if (low_band_i)
					lf_q <= wdata_i;
				else
					hf_q <= wdata_i;
			end
		end
		assign lf_flat[g*8 +: 8] = lf_q;
		assign hf_flat[g*8 +: 8] = hf_q;
	end

	// Bank chosen by the band page bit
	always_comb
	begin
		rdata_o = 8'h00;
		if (32'(idx_i) < DEPTH)
			rdata_o = low_band_i ? lf_flat[{idx_i, 3'b000} +: 8] : hf_flat[{idx_i, 3'b000} +: 8];
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_LF_WRITE_KEEPS_HF: assert property (wr_i && low_band_i |=> $stable(hf_flat))
		else $error("High band bank changed on low band write");
	AST_HF_WRITE_KEEPS_LF: assert property (wr_i && !low_band_i |=> $stable(lf_flat))
		else $error("Low band bank changed on high band write");

endmodule

// >>> hdl/mpm_regs.sv
// Modem page register bank: FIFO port, mode control, carrier word, paging.
// Assumes an AXI4-Lite master on CORE_CLK_I and page/FIFO logic on the same clock.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ns
module mpm_regs
#(
	parameter int ADDR_W = 12
)
(
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	output logic [7:0] FIFO_WDATA_O,
	output logic FIFO_WR_O,
	output logic FIFO_RD_O,
	input wire logic [7:0] FIFO_RDATA_I,
	output logic FIFO_FLUSH_O,
	output mpm_pkg::mpm_mode_t MODE_O,
	output logic MODE_TRIG_O,
	output logic MODEM_FAMILY_O,
	output logic SHARED_PAGE_O,
	output logic LOW_BAND_PAGE_O,
	output logic [23:0] CARRIER_WORD_O,
	output logic CARRIER_LOAD_O,
	output logic PAGE_WR_O,
	output logic PAGE_RD_O,
	output logic PAGE_MODEM_O,
	output logic [6:0] PAGE_IDX_O,
	output logic [7:0] PAGE_WDATA_O,
	input wire logic [7:0] PAGE_RDATA_I
);
	import mpm_pkg::*;

	logic have_aw;
	logic [6:0] aw_idx;
	logic aw_bad;
	logic have_w;
	logic [7:0] w_data;
	logic w_lane;
	logic rd_pend;
	logic [6:0] rd_idx;
	logic rd_bad;
	logic op_valid;
	logic op_we;
	logic [6:0] op_idx;
	logic op_bad;
	logic [7:0] op_data;
	logic op_lane;
	logic bvalid;
	logic [1:0] bresp;
	logic rvalid;
	logic [1:0] rresp;
	logic [7:0] rdata;
	mpm_mode_t mode_q;
	logic family;
	logic shared;
	logic low_band;
	logic [7:0] frf_high;
	logic [7:0] frf_mid;
	logic [7:0] frf_low;
	logic [23:0] carrier_word;
	logic wr_issue;
	logic rd_issue;
	logic op_wr;
	logic op_rd;
	logic is_sleep;
	logic in_shared;
	logic in_band;
	logic is_ext;
	logic opm_wr;
	logic frf_low_wr;
	logic band_wr;
	logic [4:0] band_idx;
	logic [7:0] band_rdata;
	logic [7:0] next_rdata;

	function automatic logic addr_bad(input logic [ADDR_W-1:0] addr);
		addr_bad = (addr >> (IDX_W + IDX_LSB)) != '0;
	endfunction

	// Issue and decode
	assign wr_issue = have_aw && have_w && !bvalid && !(op_valid && op_we);
	assign rd_issue = !wr_issue && rd_pend && !rvalid && !(op_valid && !op_we);
	assign op_wr = op_valid && op_we && !op_bad && op_lane;
	assign op_rd = op_valid && !op_we && !op_bad;
	assign is_sleep = mode_q == MPM_SLEEP;
	assign in_shared = op_idx >= IDX_SHARED_LO && op_idx <= IDX_SHARED_HI;
	assign in_band = op_idx >= IDX_BAND_LO && op_idx <= IDX_BAND_HI;
	assign is_ext = op_idx > IDX_FRF_LOW && !in_band;
	assign opm_wr = op_wr && op_idx == IDX_OPMODE;
	assign frf_low_wr = op_wr && op_idx == IDX_FRF_LOW;
	assign band_wr = op_wr && in_band;
	assign band_idx = 5'(op_idx - IDX_BAND_LO);

	// Write address capture
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			have_aw <= 1'b0;
			aw_idx <= '0;
			aw_bad <= 1'b0;
		end
		else if (S_AXI_AWVALID_I && !have_aw)
		begin
			have_aw <= 1'b1;
			aw_idx <= S_AXI_AWADDR_I[IDX_W+IDX_LSB-1:IDX_LSB];
			aw_bad <= addr_bad(S_AXI_AWADDR_I);
		end
		else if (wr_issue)
			have_aw <= 1'b0;
	end

	// Write data capture, low byte lane only
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			have_w <= 1'b0;
			w_data <= 8'h00;
			w_lane <= 1'b0;
		end
		else if (S_AXI_WVALID_I && !have_w)
		begin
			have_w <= 1'b1;
			w_data <= S_AXI_WDATA_I[7:0];
			w_lane <= S_AXI_WSTRB_I[0];
		end
		else if (wr_issue)
			have_w <= 1'b0;
	end

	// Read address capture
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			rd_pend <= 1'b0;
			rd_idx <= '0;
			rd_bad <= 1'b0;
		end
		else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
		begin
			rd_pend <= 1'b1;
			rd_idx <= S_AXI_ARADDR_I[IDX_W+IDX_LSB-1:IDX_LSB];
			rd_bad <= addr_bad(S_AXI_ARADDR_I);
		end
		else if (rd_issue)
			rd_pend <= 1'b0;
	end

	// One access executes per cycle, writes first
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			op_valid <= 1'b0;
			op_we <= 1'b0;
			op_idx <= '0;
			op_bad <= 1'b0;
			op_data <= 8'h00;
			op_lane <= 1'b0;
		end
		else
		begin
			op_valid <= wr_issue || rd_issue;
			if (wr_issue)
			begin
				op_we <= 1'b1;
				op_idx <= aw_idx;
				op_bad <= aw_bad;
				op_data <= w_data;
				op_lane <= w_lane;
			end
			else if (rd_issue)
			begin
				op_we <= 1'b0;
				op_idx <= rd_idx;
				op_bad <= rd_bad;
				op_lane <= 1'b0;
			end
		end
	end

	// Write response
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end
		else if (op_valid && op_we)
		begin
			bvalid <= 1'b1;
			bresp <= op_bad ? RESP_SLVERR : RESP_OKAY;
		end
		else if (S_AXI_BREADY_I)
			bvalid <= 1'b0;
	end

	// Read data select
	always_comb
	begin
		next_rdata = 8'h00;
		if (in_band)
			next_rdata = band_rdata;
		else if (is_ext)
			next_rdata = PAGE_RDATA_I;
		else
		begin
			case (op_idx)
				IDX_FIFO: next_rdata = is_sleep ? 8'h00 : FIFO_RDATA_I;
				IDX_OPMODE: next_rdata = {family, shared, 2'b00, low_band, mode_q};
				IDX_FRF_HIGH: next_rdata = frf_high;
				IDX_FRF_MID: next_rdata = frf_mid;
				IDX_FRF_LOW: next_rdata = frf_low;
				default: next_rdata = 8'h00;
			endcase
		end
	end

	// Read response
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			rvalid <= 1'b0;
			rresp <= RESP_OKAY;
			rdata <= 8'h00;
		end
		else if (op_valid && !op_we)
		begin
			rvalid <= 1'b1;
			rresp <= op_bad ? RESP_SLVERR : RESP_OKAY;
			rdata <= op_bad ? 8'h00 : next_rdata;
		end
		else if (S_AXI_RREADY_I)
			rvalid <= 1'b0;
	end

	// Mode control register
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			family <= FAMILY_RST;
			shared <= SHARED_RST;
			low_band <= LOWBAND_RST;
			mode_q <= MPM_STANDBY_STATE;
		end
		else if (opm_wr)
		begin
			if (is_sleep)
				family <= op_data[OPM_FAMILY_BIT];
			shared <= op_data[OPM_SHARED_BIT];
			low_band <= op_data[OPM_LOWBAND_BIT];
			mode_q <= mpm_mode_t'(op_data[OPM_MODE_MSB:0]);
		end
	end

	// Carrier bytes staged, word applied on lowest byte
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			frf_high <= FRF_HIGH_RST;
			frf_mid <= FRF_MID_RST;
			frf_low <= FRF_LOW_RST;
			carrier_word <= {FRF_HIGH_RST, FRF_MID_RST, FRF_LOW_RST};
		end
		else if (op_wr)
		begin
			if (op_idx == IDX_FRF_HIGH)
				frf_high <= op_data;
			if (op_idx == IDX_FRF_MID)
				frf_mid <= op_data;
			if (frf_low_wr)
			begin
				frf_low <= op_data;
				carrier_word <= {frf_high, frf_mid, op_data};
			end
		end
	end

	mpm_band_store #(.DEPTH(BAND_DEPTH)) u_band
	(
		.clk_i(CORE_CLK_I),
		.rst_i(RST_I),
		.low_band_i(low_band),
		.wr_i(band_wr),
		.idx_i(band_idx),
		.wdata_i(op_data),
		.rdata_o(band_rdata)
	);

	// Bus handshakes
	assign S_AXI_AWREADY_O = !have_aw;
	assign S_AXI_WREADY_O = !have_w;
	assign S_AXI_ARREADY_O = !rd_pend && !rvalid && !(op_valid && !op_we);
	assign S_AXI_BVALID_O = bvalid;
	assign S_AXI_BRESP_O = bresp;
	assign S_AXI_RVALID_O = rvalid;
	assign S_AXI_RRESP_O = rresp;
	assign S_AXI_RDATA_O = {24'h000000, rdata};

	// FIFO port, closed in sleep
	assign FIFO_FLUSH_O = is_sleep;
	assign FIFO_WR_O = op_wr && op_idx == IDX_FIFO && !is_sleep;
	assign FIFO_RD_O = op_rd && op_idx == IDX_FIFO && !is_sleep;
	assign FIFO_WDATA_O = op_data;

	// Mode and carrier outputs, trigger pulses
	assign MODE_O = mode_q;
	assign MODE_TRIG_O = opm_wr;
	assign MODEM_FAMILY_O = family;
	assign SHARED_PAGE_O = shared;
	assign LOW_BAND_PAGE_O = low_band;
	assign CARRIER_WORD_O = carrier_word;
	assign CARRIER_LOAD_O = frf_low_wr;

	// Page routing
	assign PAGE_MODEM_O = family && !(shared && in_shared);
	assign PAGE_WR_O = op_wr && is_ext;
	assign PAGE_RD_O = op_rd && is_ext;
	assign PAGE_IDX_O = op_idx;
	assign PAGE_WDATA_O = op_data;

	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);

	sequence seq_read_taken;
		S_AXI_ARVALID_I && S_AXI_ARREADY_O;
	endsequence
	sequence seq_read_answer;
		##[3:4] S_AXI_RVALID_O;
	endsequence
	sequence seq_mode_write;
		opm_wr && MODE_TRIG_O;
	endsequence

	AST_FAMILY_ONLY_IN_SLEEP: assert property ($changed(family) |-> $past(opm_wr) && $past(is_sleep))
		else $error("Family bit changed outside sleep");
	AST_SHARED_TO_FSK: assert property (op_valid && family && shared && in_shared |-> !PAGE_MODEM_O)
		else $error("Shared range not routed to FSK page");
	AST_PAGE_FOLLOWS_FAMILY: assert property (op_valid && is_ext && !(family && shared && in_shared) |-> PAGE_MODEM_O == family)
		else $error("Page select does not follow family");
	AST_FIFO_CLOSED_SLEEP: assert property (mode_q == MPM_SLEEP |-> FIFO_FLUSH_O && !FIFO_WR_O && !FIFO_RD_O)
		else $error("FIFO reachable in sleep");
	AST_CARRIER_ATOMIC: assert property ($changed(CARRIER_WORD_O) |-> $past(frf_low_wr))
		else $error("Carrier word changed without low byte write");
	AST_CARRIER_VALUE: assert property (frf_low_wr |=> CARRIER_WORD_O == {$past(frf_high), $past(frf_mid), $past(op_data)})
		else $error("Carrier word not assembled from bytes");
	AST_MODE_TRIGGER: assert property (seq_mode_write |=> MODE_O == $past(op_data[2:0]))
		else $error("Mode write not applied");
	AST_RESET_VALUES: assert property ($past(RST_I) |-> LOW_BAND_PAGE_O && MODE_O == MPM_STANDBY_STATE && CARRIER_WORD_O == 24'h6C8000)
		else $error("Wrong values after reset");
	AST_READ_LATENCY: assert property (seq_read_taken |-> seq_read_answer)
		else $error("Read answer late");

endmodule

// >>> dv/testbench.sv
// Self-checking bench for the modem page register bank.
// Assumes mpm_regs alone on one clock, driven over AXI4-Lite by this bench.
`timescale 1ns/1ns
module testbench;
import mpm_pkg::*;
logic clk = 1'b0;
logic rst = 1'b1;
logic [11:0] awaddr = 12'h000, araddr = 12'h000;
logic [31:0] wdata = 32'h0;
logic [3:0] wstrb = 4'h0;
logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
logic [7:0] fifo_rdata = 8'h00, pg_rdata = 8'h00;
logic awready, wready, bvalid, arready, rvalid, fifo_wr, fifo_rd, fifo_flush;
logic [1:0] bresp, rresp;
logic [31:0] rdata;
logic [7:0] fifo_wdata, pg_wdata;
mpm_mode_t mode;
logic trig, fam, shared, lowb, load, pg_wr, pg_rd, pg_modem;
logic [23:0] word;
logic [6:0] pg_idx;
int failures = 0, checks_done = 0;
int n_fwr = 0, n_frd = 0, n_trig = 0, n_load = 0, n_pwr = 0, n_prd = 0;

mpm_regs uut (.CORE_CLK_I(clk), .RST_I(rst),
	.S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
	.S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
	.S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
	.S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
	.S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
	.S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .FIFO_WDATA_O(fifo_wdata),
	.FIFO_WR_O(fifo_wr), .FIFO_RD_O(fifo_rd), .FIFO_RDATA_I(fifo_rdata),
	.FIFO_FLUSH_O(fifo_flush), .MODE_O(mode), .MODE_TRIG_O(trig), .MODEM_FAMILY_O(fam),
	.SHARED_PAGE_O(shared), .LOW_BAND_PAGE_O(lowb), .CARRIER_WORD_O(word),
	.CARRIER_LOAD_O(load), .PAGE_WR_O(pg_wr), .PAGE_RD_O(pg_rd), .PAGE_MODEM_O(pg_modem),
	.PAGE_IDX_O(pg_idx), .PAGE_WDATA_O(pg_wdata), .PAGE_RDATA_I(pg_rdata));

always #5 clk = ~clk;

// Side pulse counters
always @(posedge clk)
begin
	n_fwr += int'(fifo_wr === 1'b1);
	n_frd += int'(fifo_rd === 1'b1);
	n_trig += int'(trig === 1'b1);
	n_load += int'(load === 1'b1);
	n_pwr += int'(pg_wr === 1'b1);
	n_prd += int'(pg_rd === 1'b1);
end

// Carrier frequency in kHz from the word and the reference
function automatic logic [31:0] carrier_khz(logic [23:0] w);
	return 32'((64'(w) * REF_OSC_FREQ_MHZ * 1000) >> FRF_FRAC_BITS);
endfunction

function automatic logic [7:0] opm(logic f, logic s, logic l, logic [2:0] m);
	return {f, s, 2'b00, l, m};
endfunction

function automatic logic pmod(logic f, logic s, logic [6:0] idx);
	return f && !(s && idx >= IDX_SHARED_LO && idx <= IDX_SHARED_HI);
endfunction

task automatic conclude();
	if (failures == 0 && checks_done > 0)
		$display("TB: PASS");
	else
		$display("TB: FAIL");
	$finish;
endtask

task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	checks_done++;
	if (got !== exp)
	begin
		failures++;
		$display("BAD at %0t: got %h expected %h", $time, got, exp);
	end
endtask

task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
	bit a_ok, w_ok;
	int n;
	a_ok = 1'b0;
	w_ok = 1'b0;
	r = 2'h3;
	@(posedge clk);
	awaddr <= a;
	awvalid <= 1'b1;
	wdata <= {24'h000000, d};
	wstrb <= 4'hF;
	wvalid <= 1'b1;
	bready <= 1'b1;
	for (n = 0; n < 100; n++)
	begin
		@(posedge clk);
		if (!a_ok && awready === 1'b1)
		begin
			a_ok = 1'b1;
			awvalid <= 1'b0;
		end
		if (!w_ok && wready === 1'b1)
		begin
			w_ok = 1'b1;
			wvalid <= 1'b0;
		end
		if (bvalid === 1'b1)
		begin
			r = bresp;
			bready <= 1'b0;
			break;
		end
	end
	if (n == 100)
	begin
		failures++;
		conclude();
	end
endtask

task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
	bit a_ok;
	int n;
	a_ok = 1'b0;
	@(posedge clk);
	araddr <= a;
	arvalid <= 1'b1;
	rready <= 1'b1;
	for (n = 0; n < 100; n++)
	begin
		@(posedge clk);
		if (!a_ok && arready === 1'b1)
		begin
			a_ok = 1'b1;
			arvalid <= 1'b0;
		end
		if (rvalid === 1'b1)
		begin
			d = rdata;
			r = rresp;
			rready <= 1'b0;
			break;
		end
	end
	if (n == 100)
	begin
		failures++;
		conclude();
	end
endtask

task automatic w1(input logic [6:0] idx, input logic [7:0] d);
	logic [1:0] r;
	wr({3'h0, idx, 2'h0}, d, r);
	chk(r, RESP_OKAY);
endtask

task automatic rdc(input logic [6:0] idx, input logic [7:0] exp);
	logic [1:0] r;
	logic [31:0] d;
	rd({3'h0, idx, 2'h0}, d, r);
	chk(r, RESP_OKAY);
	chk(d, {24'h000000, exp});
endtask

initial
begin
	logic [7:0] d, h, m, l;
	logic [1:0] r;
	logic [31:0] dat;
	logic [23:0] cw;
	logic [6:0] pidx [4];
	int base;
	pidx = '{7'h0D, 7'h3F, 7'h40, 7'h0C};
	void'($urandom(32'h9459));
	repeat (6) @(posedge clk);
	rst <= 1'b0;
	chk(mode, MPM_STANDBY_STATE);
	chk(word, 24'h6C8000);
	chk(carrier_khz(word), 32'h00069F50);
	chk({fam, shared, lowb}, 3'b001);
	rdc(IDX_OPMODE, opm(1'b0, 1'b0, 1'b1, 3'b001));
	rdc(IDX_FRF_HIGH, 8'h6C);
	rdc(IDX_FRF_MID, 8'h80);
	rdc(IDX_FRF_LOW, 8'h00);
	for (int k = 2; k < 6; k++)
		rdc(k[6:0], 8'h00);
	w1(IDX_OPMODE, opm(1'b1, 1'b0, 1'b1, 3'b001));
	chk(fam, 1'b0);
	// Every mode code, each write triggering
	for (int k = 0; k < 8; k++)
	begin
		base = n_trig;
		w1(IDX_OPMODE, opm(1'b0, 1'b0, 1'b1, k[2:0]));
		chk(mode, k[2:0]);
		chk(n_trig, base + 1);
		chk(fifo_flush, k == 0);
	end
	w1(IDX_OPMODE, opm(1'b0, 1'b0, 1'b1, 3'b000));
	base = n_fwr;
	w1(IDX_FIFO, 8'($urandom()));
	chk(n_fwr, base);
	fifo_rdata <= 8'($urandom());
	base = n_frd;
	rdc(IDX_FIFO, 8'h00);
	chk(n_frd, base);
	w1(IDX_OPMODE, opm(1'b1, 1'b0, 1'b1, 3'b000));
	chk(fam, 1'b1);
	w1(IDX_OPMODE, opm(1'b1, 1'b0, 1'b1, 3'b001));
	w1(IDX_OPMODE, opm(1'b0, 1'b0, 1'b1, 3'b001));
	chk(fam, 1'b1);
	d = 8'($urandom());
	base = n_fwr;
	w1(IDX_FIFO, d);
	chk(n_fwr, base + 1);
	chk(fifo_wdata, d);
	fifo_rdata <= ~d;
	base = n_frd;
	rdc(IDX_FIFO, ~d);
	chk(n_frd, base + 1);
	// Carrier word staged, applied on low byte
	cw = 24'h6C8000;
	repeat (3)
	begin
		h = 8'($urandom());
		m = 8'($urandom());
		l = 8'($urandom());
		w1(IDX_FRF_HIGH, h);
		w1(IDX_FRF_MID, m);
		chk(word, cw);
		rdc(IDX_FRF_HIGH, h);
		base = n_load;
		w1(IDX_FRF_LOW, l);
		cw = {h, m, l};
		chk(word, cw);
		chk(n_load, base + 1);
		rdc(IDX_FRF_MID, m);
	end
	// Page routing by family and shared access
	for (int f = 1; f >= 0; f--)
	begin
		w1(IDX_OPMODE, opm(f[0], 1'b0, 1'b1, 3'b000));
		w1(IDX_OPMODE, opm(f[0], 1'b0, 1'b1, 3'b000));
		chk(fam, f[0]);
		for (int s = 0; s < 2; s++)
		begin
			w1(IDX_OPMODE, opm(f[0], s[0], 1'b1, 3'b000));
			chk(shared, s[0]);
			foreach (pidx[j])
			begin
				d = 8'($urandom());
				base = n_pwr;
				w1(pidx[j], d);
				chk(n_pwr, base + 1);
				chk({pg_idx, pg_wdata}, {pidx[j], d});
				chk(pg_modem, pmod(f[0], s[0], pidx[j]));
				pg_rdata <= ~d;
				base = n_prd;
				rdc(pidx[j], ~d);
				chk(n_prd, base + 1);
			end
		end
	end
	w1(IDX_OPMODE, opm(1'b0, 1'b0, 1'b1, 3'b000));
	// Two retained band banks
	for (int k = IDX_BAND_LO; k <= IDX_BAND_HI; k += 18)
	begin
		h = 8'($urandom());
		l = 8'($urandom());
		w1(k[6:0], h);
		w1(IDX_OPMODE, opm(1'b0, 1'b0, 1'b0, 3'b000));
		chk(lowb, 1'b0);
		w1(k[6:0], l);
		rdc(k[6:0], l);
		w1(IDX_OPMODE, opm(1'b0, 1'b0, 1'b1, 3'b000));
		rdc(k[6:0], h);
	end
	wr(12'h200, 8'h11, r);
	chk(r, RESP_SLVERR);
	rd(12'h200, dat, r);
	chk(r, RESP_SLVERR);
	chk(dat, 32'h00000000);
	conclude();
end

endmodule
